/* File: rtl/tsmx_pkg.sv */
// constants shared by the timer/status/misc instruction executor
package tsmx_pkg;

  // ------------------------------------------------------------
  // register byte offsets on the avalon slave
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_OPND = 8'h04;
  localparam logic [7:0] OFS_ACC = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_PTR = 8'h14;
  localparam logic [7:0] OFS_PRELOAD = 8'h18;
  localparam logic [7:0] OFS_PC = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_ROMADDR = 8'h24;
  localparam logic [7:0] OFS_ROMDATA = 8'h28;
  localparam logic [1:0] OFS_WREG_HI = 2'h1; // 0x40..0x7c

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int FLG_CARRY = 0;
  localparam int FLG_MATCH = 1;
  localparam int FLG_STBY = 2;
  localparam int FLG_UNK = 3;
  localparam int FLG_COND = 4;
  localparam int STS_TIMER = 4;
  localparam logic [9:0] PC_RST = 10'h000;

  // ------------------------------------------------------------
  // instruction codes; bit 5 of the timer nibble ops picks upper
  // ------------------------------------------------------------
  localparam logic [9:0] OP_NOP = 10'h000;
  localparam logic [9:0] OP_NIB_MASK = 10'h3df;
  localparam logic [9:0] OP_RDT = 10'h3df;
  localparam logic [9:0] OP_WRT = 10'h09f;
  localparam logic [9:0] OP_TIMM = 10'h0df;
  localparam logic [9:0] OP_TIND = 10'h0ff;
  localparam logic [9:0] OP_HALT = 10'h051;
  localparam logic [9:0] OP_STTR_MASK = 10'h3f0;
  localparam logic [9:0] OP_STTR = 10'h060;
  localparam logic [9:0] OP_STTI = 10'h071;
  localparam logic [9:0] OP_SET_CARRY_ALL_ONES_OP = 10'h353;
  localparam logic [9:0] OP_JF = 10'h1d1;
  localparam logic [9:0] OP_JNF = 10'h1f1;

  // ------------------------------------------------------------
  // timer base periods in oscillator cycles (osc_freq = core_clk)
  // ------------------------------------------------------------
  localparam int TMR_BASE_LO = 64;
  localparam int TMR_BASE_HI = 128;

  // operand word t1 t9..t6 t0 t5..t2 to preload t9..t0
  function automatic logic [9:0] tsmx_unpack(input logic [9:0] w);
    return {w[8:5], w[3:0], w[9], w[4]};
  endfunction

endpackage

/* File: rtl/tsmx_rom.sv */
// program memory, one write port, registered read data
`timescale 1ns/1ns
module tsmx_rom #(
  parameter int AW = 10,
  parameter int DW = 10
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // load port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  // fetch port
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [2**AW];

  // memory array has no reset, it is loaded by software
  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // read register
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule // tsmx_rom

/* File: rtl/tsmx_timer.sv */
// interval timer: (preload + 1) base periods, sticky expiry
`timescale 1ns/1ns
module tsmx_timer
  import tsmx_pkg::*;
#(
  parameter int TW = 10,
  parameter int PW = 7
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic reload_i,
  input wire logic [TW-1:0] preload_i,
  input wire logic base_sel_i,
  // status
  output logic expired_o
);
  logic [PW-1:0] presc_reg;
  logic [TW-1:0] count_reg;
  logic [17:0] elapsed_reg;
  logic [PW-1:0] base_last;
  logic tick;

  assign base_last = base_sel_i ? PW'(TMR_BASE_HI - 1) : PW'(TMR_BASE_LO - 1);
  assign tick = (presc_reg == base_last) && !expired_o;

  // prescaler: one-cycle enable every base period
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || reload_i) begin
      presc_reg <= '0;
    end else if (!expired_o) begin
      presc_reg <= tick ? '0 : presc_reg + 1'b1;
    end
  end

  // [RULE4] interval count
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      count_reg <= '0;
    end else if (reload_i) begin
      count_reg <= preload_i;
    end else if (tick && count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  // [RULE12] expiry stays until reload
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || reload_i) begin
      expired_o <= 1'b0;
    end else if (tick && count_reg == '0) begin
      expired_o <= 1'b1;
    end
  end

  // helper for checking: cycles since reload
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || reload_i) begin
      elapsed_reg <= '0;
    end else if (!expired_o) begin
      elapsed_reg <= elapsed_reg + 1'b1;
    end
  end

  a_timer_interval: assert property ( // [RULE4]
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(expired_o) && !$past(reload_i, 2) |->
      elapsed_reg == (18'(preload_i) + 18'd1) *
        (base_sel_i ? 18'(TMR_BASE_HI) : 18'(TMR_BASE_LO)))
    else $error("timer interval wrong");

  a_timer_sticky: assert property ( // [RULE12]
    @(posedge core_clk_i) disable iff (!rst_n_i)
    expired_o && !reload_i |=> expired_o)
    else $error("timer status dropped without reload");
endmodule // tsmx_timer

/* File: rtl/tsmx_exec.sv */
// timer, status test and misc instruction executor on avalon-mm
// Contract
// [RULE1] read nibble op loads acc from t9..t6 or t5..t2, clears carry
// [RULE2] write nibble op stores acc in t9..t6/t5..t2, clearing t1/t0
// [RULE3] immediate timer load unpacks t1 t9..t6 t0 t5..t2 operand
// [RULE4] interval is (preload + 1) times 64 or 128 oscillator cycles
// [RULE5] indirect timer load reads memory at page and pointer pair
// [RULE6] two-word standby op enters standby, operand picks release
// [RULE7] register status test sets match if any selected status is on
// [RULE8] immediate status test does the same against the operand
// [RULE9] set-carry op sets carry if acc is all ones, keeps low ones
// [RULE10] all-zero word only advances program counter by one
// [RULE11] branch on match loads target if set, else skips two words
// [RULE12] timer status stays up from expiry until the next reload
`timescale 1ns/1ns
module tsmx_exec
  import tsmx_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // status sources
  input wire logic sense_input_zero_i,
  input wire logic sense_input_one_i,
  input wire logic [7:0] bidir_key_port_i,
  input wire logic [3:0] key_input_port_i,
  // core state
  output logic standby_o,
  output logic status_match_o,
  output logic carry_bit_o,
  output logic timer_status_o
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [3:0] acc_reg;
  logic [9:0] pc_reg;
  logic [9:0] preload_reg;
  logic [9:0] opnd_reg;
  logic [9:0] instr_reg;
  logic [7:0] pointer_pair;
  logic [1:0] rom_page_register;
  logic [9:0] romaddr_reg;
  logic [3:0] cond_reg;
  logic unk_reg;
  logic base_sel_reg;
  logic reload_reg;
  logic [3:0] working_register_n [16];
  logic [9:0] rom_rdata;
  logic timer_exp;
  logic [31:0] rd_mux;
  logic [31:0] wmerge;
  logic [9:0] op;
  logic [3:0] svec;
  logic [3:0] sel_mask;
  logic [3:0] set_carry_all_ones_op_val;
  logic [3:0] nib;
  logic [9:0] jtarget;
  logic acc_go;
  logic exec;
  logic hit;
  logic is_rdt, is_wrt, is_timm, is_tind, is_halt;
  logic is_sttr, is_stti, is_set_carry_all_ones_op, is_nop, is_jf, is_jnf;
  logic known;
  logic two_word;
  logic taken;

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  // a request waits one cycle so memory fetch and read mux settle
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (avs_waitrequest_o) begin
      avs_waitrequest_o <= !(avs_read_i || avs_write_i);
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // read data registered at the edge that drops waitrequest
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= '0;
    end else if (avs_waitrequest_o && avs_read_i) begin
      avs_readdata_o <= rd_mux;
    end
  end

  assign acc_go = !avs_waitrequest_o && avs_write_i;
  // instructions are refused while in standby, but still acknowledged
  assign exec = acc_go && avs_address_i == OFS_INSTR && !standby_o;

  // status vector: key ports share one bit
  assign svec = {timer_exp, (|bidir_key_port_i) | (|key_input_port_i),
                 sense_input_one_i, sense_input_zero_i};

  // read mux, unmapped addresses read zero
  always_comb begin
    rd_mux = '0;
    if (avs_address_i[7:6] == OFS_WREG_HI) begin
      rd_mux[3:0] = working_register_n[avs_address_i[5:2]];
    end else begin
      case (avs_address_i)
        OFS_INSTR: rd_mux[9:0] = instr_reg;
        OFS_OPND: rd_mux[9:0] = opnd_reg;
        OFS_ACC: rd_mux[3:0] = acc_reg;
        OFS_FLAGS: rd_mux[7:0] = {cond_reg, unk_reg, standby_o,
                                  status_match_o, carry_bit_o};
        OFS_CTRL: rd_mux[0] = base_sel_reg;
        OFS_PTR: rd_mux[9:0] = {rom_page_register, pointer_pair};
        OFS_PRELOAD: rd_mux[9:0] = preload_reg;
        OFS_PC: rd_mux[9:0] = pc_reg;
        OFS_STATUS: rd_mux[4:0] = {timer_exp, svec};
        OFS_ROMADDR: rd_mux[9:0] = romaddr_reg;
        default: rd_mux = '0;
      endcase
    end
  end

  // byte enables merge write data over current contents
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmerge[8*i +: 8] = avs_byteenable_i[i] ? avs_writedata_i[8*i +: 8]
                                             : rd_mux[8*i +: 8];
    end
  end

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  assign op = wmerge[9:0];

  // opcode compare, nibble ops ignore the upper/lower select
  always_comb begin
    is_rdt = (op & OP_NIB_MASK) == OP_RDT;
    is_wrt = (op & OP_NIB_MASK) == OP_WRT;
    is_timm = op == OP_TIMM;
    is_tind = op == OP_TIND;
    is_halt = op == OP_HALT;
    is_sttr = (op & OP_STTR_MASK) == OP_STTR;
    is_stti = op == OP_STTI;
    is_set_carry_all_ones_op = op == OP_SET_CARRY_ALL_ONES_OP;
    is_nop = op == OP_NOP;
    is_jf = op == OP_JF;
    is_jnf = op == OP_JNF;
    known = is_rdt | is_wrt | is_timm | is_tind | is_halt | is_sttr |
            is_stti | is_set_carry_all_ones_op | is_nop | is_jf | is_jnf;
  end

  // [RULE7] [RULE8] status coincidence
  assign sel_mask = is_sttr ? working_register_n[op[3:0]] : opnd_reg[3:0];
  assign hit = |(svec & sel_mask);

  // [RULE9] only the run of low ones survives
  assign set_carry_all_ones_op_val = acc_reg[0] ? (acc_reg[1] ? (acc_reg[2] ?
                    (acc_reg[3] ? 4'hf : 4'h7) : 4'h3) : 4'h1) : 4'h0;

  // [RULE1] nibble select
  assign nib = op[5] ? preload_reg[9:6] : preload_reg[5:2];

  // [RULE11] branch target from a9 a7..a4 a8 a3..a0
  assign jtarget = {opnd_reg[9], opnd_reg[4], opnd_reg[8:5], opnd_reg[3:0]};
  assign taken = (is_jf && status_match_o) || (is_jnf && !status_match_o);
  assign two_word = is_timm | is_halt | is_stti | is_jf | is_jnf;

  // ------------------------------------------------------------
  // execution state
  // ------------------------------------------------------------
  // accumulator
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      acc_reg <= '0;
    end else if (exec && is_rdt) begin
      acc_reg <= nib;
    end else if (exec && is_set_carry_all_ones_op) begin
      acc_reg <= set_carry_all_ones_op_val;
    end else if (acc_go && avs_address_i == OFS_ACC) begin
      acc_reg <= wmerge[3:0];
    end
  end

  // carry bit
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      carry_bit_o <= 1'b0;
    end else if (exec && is_rdt) begin
      carry_bit_o <= 1'b0;
    end else if (exec && is_set_carry_all_ones_op) begin
      carry_bit_o <= acc_reg == 4'hf;
    end else if (acc_go && avs_address_i == OFS_FLAGS) begin
      carry_bit_o <= wmerge[FLG_CARRY];
    end
  end

  // status match bit
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      status_match_o <= 1'b0;
    end else if (exec && (is_sttr || is_stti)) begin
      status_match_o <= hit;
    end else if (acc_go && avs_address_i == OFS_FLAGS) begin
      status_match_o <= wmerge[FLG_MATCH];
    end
  end

  // unknown opcode sticky, write one clears, a new set wins
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      unk_reg <= 1'b0;
    end else if (exec && !known) begin
      unk_reg <= 1'b1;
    end else if (acc_go && avs_address_i == OFS_FLAGS && wmerge[FLG_UNK]) begin
      unk_reg <= 1'b0;
    end
  end

  // [RULE6] standby entry and release
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      standby_o <= 1'b0;
      cond_reg <= '0;
    end else if (exec && is_halt) begin
      standby_o <= 1'b1;
      cond_reg <= opnd_reg[3:0];
    end else if (standby_o && |(svec & cond_reg)) begin
      standby_o <= 1'b0;
    end
  end

  // [RULE10] [RULE11] program counter
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pc_reg <= PC_RST;
    end else if (exec) begin
      if (taken) begin
        pc_reg <= jtarget;
      end else begin
        pc_reg <= pc_reg + (two_word ? 10'd2 : 10'd1);
      end
    end
  end

  // [RULE2] [RULE3] [RULE5] timer preload word
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      preload_reg <= '0;
    end else if (exec && is_wrt && op[5]) begin
      preload_reg <= {acc_reg, preload_reg[5:2], 1'b0, preload_reg[0]};
    end else if (exec && is_wrt) begin
      preload_reg <= {preload_reg[9:6], acc_reg, preload_reg[1], 1'b0};
    end else if (exec && is_timm) begin
      preload_reg <= tsmx_unpack(opnd_reg);
    end else if (exec && is_tind) begin
      preload_reg <= tsmx_unpack(rom_rdata);
    end
  end

  // timer restarts the cycle after its preload changes
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reload_reg <= 1'b0;
    end else begin
      reload_reg <= exec && (is_wrt || is_timm || is_tind);
    end
  end

  // plain software registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      instr_reg <= '0;
      opnd_reg <= '0;
      base_sel_reg <= 1'b0;
      pointer_pair <= '0;
      rom_page_register <= '0;
    end else if (acc_go) begin
      case (avs_address_i)
        OFS_INSTR: instr_reg <= op;
        OFS_OPND: opnd_reg <= op;
        OFS_CTRL: base_sel_reg <= wmerge[0];
        OFS_PTR: {rom_page_register, pointer_pair} <= op;
        default: ;
      endcase
    end
  end

  // memory load address, steps after each data write
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      romaddr_reg <= '0;
    end else if (acc_go && avs_address_i == OFS_ROMADDR) begin
      romaddr_reg <= op;
    end else if (acc_go && avs_address_i == OFS_ROMDATA) begin
      romaddr_reg <= romaddr_reg + 1'b1;
    end
  end

  // working registers, one per entry
  for (genvar n = 0; n < 16; n++) begin : g_wreg
    always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
        working_register_n[n] <= '0;
      end else if (acc_go && avs_address_i == {OFS_WREG_HI, 4'(n), 2'b00})
      begin
        working_register_n[n] <= wmerge[3:0];
      end
    end
  end

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  // [RULE5] fetch address is page over pointer pair
  tsmx_rom #(.AW(10), .DW(10)) u_rom (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .we_i(acc_go && avs_address_i == OFS_ROMDATA),
    .waddr_i(romaddr_reg),
    .wdata_i(op),
    .raddr_i({rom_page_register, pointer_pair}),
    .rdata_o(rom_rdata)
  );

  tsmx_timer #(.TW(10), .PW(7)) u_timer (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .reload_i(reload_reg),
    .preload_i(preload_reg),
    .base_sel_i(base_sel_reg),
    .expired_o(timer_exp)
  );

  // output copy kept in a flop
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      timer_status_o <= 1'b0;
    end else begin
      timer_status_o <= timer_exp;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_read_nibble: assert property ( // [RULE1]
    exec && is_rdt |=> !carry_bit_o && acc_reg == ($past(op[5]) ?
      $past(preload_reg[9:6]) : $past(preload_reg[5:2])))
    else $error("nibble read wrong");

  a_write_nibble: assert property ( // [RULE2]
    exec && is_wrt |=> ($past(op[5]) ? preload_reg[9:6] == $past(acc_reg) &&
      !preload_reg[1] : preload_reg[5:2] == $past(acc_reg) &&
      !preload_reg[0]))
    else $error("nibble write wrong");

  a_imm_load: assert property ( // [RULE3]
    exec && is_timm |=> preload_reg == {$past(opnd_reg[8:5]),
      $past(opnd_reg[3:0]), $past(opnd_reg[9]), $past(opnd_reg[4])})
    else $error("immediate timer load wrong");

  a_ptr_load: assert property ( // [RULE5]
    exec && is_tind |=> preload_reg == tsmx_unpack($past(rom_rdata))
      && reload_reg)
    else $error("indirect timer load wrong");

  a_standby_entry: assert property ( // [RULE6]
    exec && is_halt |=> standby_o && cond_reg == $past(opnd_reg[3:0])
      && pc_reg == $past(pc_reg) + 10'd2)
    else $error("standby entry wrong");

  a_status_reg: assert property ( // [RULE7]
    exec && is_sttr |=> status_match_o ==
      $past(|(svec & working_register_n[op[3:0]])))
    else $error("register status test wrong");

  a_status_imm: assert property ( // [RULE8]
    exec && is_stti |=> status_match_o == $past(|(svec & opnd_reg[3:0])))
    else $error("immediate status test wrong");

  a_set_carry: assert property ( // [RULE9]
    exec && is_set_carry_all_ones_op |=> carry_bit_o == ($past(acc_reg) == 4'hf) &&
      (acc_reg & ~$past(acc_reg)) == 4'h0)
    else $error("set carry op wrong");

  a_nop_step: assert property ( // [RULE10]
    exec && is_nop |=> pc_reg == $past(pc_reg) + 10'd1 && $stable(acc_reg))
    else $error("nop did more than step");

  a_branch_match: assert property ( // [RULE11]
    exec && (is_jf || is_jnf) |=> pc_reg == ($past(taken) ?
      $past(jtarget) : $past(pc_reg) + 10'd2))
    else $error("branch on match wrong");
endmodule // tsmx_exec

/* File: bench/test_tsmx_exec.sv */
// self-checking bench for the timer, status and misc instruction executor
`timescale 1ns/1ns
module test_tsmx_exec;
  import tsmx_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic wait_o;
  logic s0 = 1'b0;
  logic s1 = 1'b0;
  logic [7:0] kio = 8'h00;
  logic [3:0] ki = 4'h0;
  logic stby, match, carry, tstat;
  logic [31:0] q;
  logic [31:0] p;
  int mismatches = 0;
  int checks = 0;

  // 100 ns clock
  always #50 core_clk_i = ~core_clk_i;

  // byte lanes tied: partial writes are not part of these rules
  tsmx_exec uut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
    .sense_input_zero_i(s0), .sense_input_one_i(s1),
    .bidir_key_port_i(kio), .key_input_port_i(ki),
    .standby_o(stby), .status_match_o(match),
    .carry_bit_o(carry), .timer_status_o(tstat)
  );

  // ------------------------------------------------------------
  // compare, bus and instruction tasks
  // ------------------------------------------------------------
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low; read data taken there
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    @(posedge core_clk_i);
    while (wait_o !== 1'b0 && n < 50) begin
      @(posedge core_clk_i);
      n++;
    end
    if (n >= 50) begin
      mismatches++;
      $display("Error at %0t: no bus answer", $time);
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task ex(input logic [9:0] op);
    bus(1'b1, OFS_INSTR, {22'h00_0000, op});
    // core outputs flip at the ack edge itself; let it pass before looking
    @(posedge core_clk_i);
  endtask

  // operand word always goes first
  task ex2(input logic [9:0] op, input logic [9:0] opnd);
    bus(1'b1, OFS_OPND, {22'h00_0000, opnd});
    ex(op);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_nibbles;
    bus(1'b1, OFS_FLAGS, 32'h0000_0001);
    ex2(OP_TIMM, 10'h3d3);
    bus(1'b0, OFS_PRELOAD, 32'h0000_0000);
    chk_word(q, 32'h0000_038f);
    ex(OP_RDT | 10'h020);
    chk_bit(carry, 1'b0);
    bus(1'b0, OFS_ACC, 32'h0000_0000);
    chk_word(q, 32'h0000_000e);
    ex(OP_RDT);
    bus(1'b0, OFS_ACC, 32'h0000_0000);
    chk_word(q, 32'h0000_0003);
    bus(1'b1, OFS_ACC, 32'h0000_0009);
    ex(OP_WRT | 10'h020);
    bus(1'b0, OFS_PRELOAD, 32'h0000_0000);
    chk_word(q, 32'h0000_024d);
    bus(1'b1, OFS_ACC, 32'h0000_0006);
    ex(OP_WRT);
    bus(1'b0, OFS_PRELOAD, 32'h0000_0000);
    chk_word(q, 32'h0000_0258);
  endtask

  // decoy word on page 0 catches a missing page bit
  task t_indirect;
    bus(1'b1, OFS_ROMADDR, 32'h0000_0023);
    bus(1'b1, OFS_ROMDATA, 32'h0000_0000);
    bus(1'b1, OFS_ROMADDR, 32'h0000_0123);
    bus(1'b1, OFS_ROMDATA, 32'h0000_02a5);
    bus(1'b1, OFS_PTR, 32'h0000_0123);
    ex(OP_TIND);
    bus(1'b0, OFS_PRELOAD, 32'h0000_0000);
    chk_word(q, 32'h0000_0156);
  endtask

  task t_status;
    logic [9:0] b;
    for (int i = 0; i < 4; i++) begin
      s0 <= (i == 0);
      s1 <= (i == 1);
      kio <= {(i == 2), 7'h00};
      ki <= {3'h0, (i == 3)};
      b = 10'h001 << ((i < 3) ? i : 2);
      ex2(OP_STTI, b);
      chk_bit(match, 1'b1);
      ex2(OP_STTI, ~b & 10'h007);
      chk_bit(match, 1'b0);
    end
    s0 <= 1'b0;
    ki <= 4'h0;
    s1 <= 1'b1;
    bus(1'b1, 8'h54, 32'h0000_0002);
    ex(OP_STTR | 10'h005);
    chk_bit(match, 1'b1);
    s1 <= 1'b0;
    ex(OP_STTR | 10'h005);
    chk_bit(match, 1'b0);
  endtask

  // preload 0 on base 64, then preload 1 on base 128
  task t_timer;
    int n;
    int e;
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, OFS_CTRL, s);
      ex2(OP_TIMM, (s == 1) ? 10'h010 : 10'h000);
      e = (s + 1) * ((s == 1) ? TMR_BASE_HI : TMR_BASE_LO);
      n = 0;
      // old expiry stays visible for a few cycles after the reload
      while ((n < 4 || tstat !== 1'b1) && n < 1000) begin
        @(posedge core_clk_i);
        n++;
        if (n == 4) chk_bit(tstat, 1'b0);
      end
      chk_bit(n >= e && n <= e + 4, 1'b1);
      ex2(OP_STTI, 10'h008);
      chk_bit(match, 1'b1);
      bus(1'b0, OFS_STATUS, 32'h0000_0000);
      chk_bit(q[3], 1'b1);
    end
  endtask

  // acc keeps its run of low ones; carry only for all ones
  task t_set_carry_all_ones_op;
    for (int a = 0; a < 16; a++) begin
      bus(1'b1, OFS_ACC, a);
      ex(OP_SET_CARRY_ALL_ONES_OP);
      bus(1'b0, OFS_ACC, 32'h0000_0000);
      chk_word(q, ((a ^ (a + 1)) >> 1) & 32'h0000_000f);
      chk_bit(carry, a == 15);
    end
  endtask

  task t_pc;
    bus(1'b0, OFS_PC, 32'h0000_0000);
    p = q;
    ex(OP_NOP);
    bus(1'b0, OFS_PC, 32'h0000_0000);
    chk_word(q, p + 1);
    ex2(OP_STTI, 10'h000);
    ex2(OP_JF, 10'h00c);
    bus(1'b0, OFS_PC, 32'h0000_0000);
    chk_word(q, p + 5);
    ex2(OP_JNF, 10'h00c);
    bus(1'b0, OFS_PC, 32'h0000_0000);
    chk_word(q, 32'h0000_000c);
    s0 <= 1'b1;
    ex2(OP_STTI, 10'h001);
    ex2(OP_JF, 10'h00a);
    bus(1'b0, OFS_PC, 32'h0000_0000);
    chk_word(q, 32'h0000_000a);
    ex2(OP_JF, 10'h215);
    bus(1'b0, OFS_PC, 32'h0000_0000);
    chk_word(q, 32'h0000_0305);
    s0 <= 1'b0;
  endtask

  // standby on sense zero, instruction ignored, released by the source
  task t_halt;
    int n;
    ex2(OP_HALT, 10'h001);
    repeat (2) @(posedge core_clk_i);
    chk_bit(stby, 1'b1);
    bus(1'b0, OFS_FLAGS, 32'h0000_0000);
    chk_word(q[7:4], 32'h0000_0001);
    bus(1'b0, OFS_PC, 32'h0000_0000);
    p = q;
    ex(OP_NOP);
    bus(1'b0, OFS_PC, 32'h0000_0000);
    chk_word(q, p);
    bus(1'b0, 8'h30, 32'h0000_0000);
    chk_word(q, 32'h0000_0000);
    s0 <= 1'b1;
    n = 0;
    while (stby !== 1'b0 && n < 10) begin
      @(posedge core_clk_i);
      n++;
    end
    chk_bit(stby, 1'b0);
    s0 <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ------------------------------------------------------------
  task test_done;
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // whole run needs under a thousand cycles
  initial begin
    #(100 * 30000);
    mismatches++;
    test_done;
  end

  initial begin
    repeat (19) @(posedge core_clk_i);
    chk_bit(wait_o, 1'b1);
    chk_bit(stby | match | carry | tstat, 1'b0);
    @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_nibbles;
    t_indirect;
    t_status;
    t_timer;
    t_set_carry_all_ones_op;
    t_pc;
    t_halt;
    test_done;
  end
endmodule // test_tsmx_exec
